// ---- ssr_pkg.sv ----
// Package for the status and service-request logic.
// Assumes a single 100 MHz clock domain and no register bus.
package ssr_pkg;

  localparam int unsigned COND_W = 16;
  localparam int unsigned STB_W = 8;
  localparam int unsigned GATE_END_BIT = 9;
  localparam int unsigned OPERATION_GROUP_SUMMARY_SUM_BIT = 7;
  localparam int unsigned MSS_BIT = 6;

  // Reset values of the programmable masks.
  localparam logic [15:0] PTR_RESET = 16'hffff;
  localparam logic [15:0] NTR_RESET = 16'h0000;
  localparam logic [15:0] ENA_RESET = 16'h0000;
  localparam logic [7:0] SRE_RESET = 8'h00;

  // Programming values for the four mask registers.
  typedef struct packed {
    logic [15:0] ptr;
    logic [15:0] ntr;
    logic [15:0] ena;
    logic [7:0] sre;
  } ssr_cfg_s;

  // Write strobes for the mask registers.
  typedef struct packed {
    logic ptr;
    logic ntr;
    logic ena;
    logic sre;
  } ssr_wr_s;

endpackage

// ---- ssr_status.sv ----
// Status reporting and service-request logic for the operation group.
// Assumes condition bits come from other clock domains or pins, and that
// mask writes and clear-status come from logic on ref_clk.
`timescale 1ns/1ns
`default_nettype none

// Function
// - Raise service request when any enabled summary condition appears.
// - Programmable transition filter chooses which condition edges reach events.
// - After reset filters pass rising edges only, block falling edges.
// - Positive filter has one enable per bit; 512 selects bit 9 only.
// - Negative filter of zero stops every falling edge setting events.
// - Event enable masks events; only enabled events set group summary.
// - End of repetitive measurement period reported on operation bit 9.
// - Operation summary at status bit 7; enable 128 requests on it.
// - Status bit 6 is master summary, set whenever service requested.
// - Event bits latch until cleared; condition tracks current state.
// - Clear-status clears events and leaves all enables unchanged.
module ssr_status
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rstn,
  // Raw operation condition bits; bit 9 is end of measurement period.
  input wire logic [15:0] operation_group_summary_cond_in,
  // Mask programming and clear-status.
  input wire ssr_pkg::ssr_cfg_s cfg_in,
  input wire ssr_pkg::ssr_wr_s cfg_wr,
  input wire logic clear_status,
  // Status outputs.
  output logic [15:0] operation_group_summary_cond,
  output logic [15:0] operation_group_summary_event,
  output ssr_pkg::ssr_cfg_s cfg_out,
  output logic [7:0] status_byte,
  output logic service_request
);

  logic [15:0] sync1_reg;
  logic [15:0] cond_reg;
  logic [15:0] cond_next;
  logic [15:0] prev_reg;
  logic [15:0] prev_next;
  logic [15:0] event_reg;
  logic [15:0] event_next;
  ssr_pkg::ssr_cfg_s cfg_reg;
  ssr_pkg::ssr_cfg_s cfg_next;
  logic srq_reg;
  logic srq_next;
  logic [15:0] edges;
  logic operation_group_summary_sum;
  logic [7:0] stb_raw;

  // Short local names for the bit positions that the checks use.
  localparam int unsigned GATE_BIT = ssr_pkg::GATE_END_BIT;
  localparam int unsigned SUM_BIT = ssr_pkg::OPERATION_GROUP_SUMMARY_SUM_BIT;
  localparam int unsigned MSS_POS = ssr_pkg::MSS_BIT;

  // All checks below run on ref_clk and sleep through reset.
  default clocking cb_check @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  // A bit passes the filter when its mask bit is set and it went from
  // low in was_val to high in now_val; swapping the two gives the falling
  // filter, so both directions share one piece of logic.
  function automatic logic [15:0] edge_pass(input logic [15:0] mask,
    input logic [15:0] now_val, input logic [15:0] was_val);
    return mask & now_val & ~was_val;
  endfunction

  // Two-stage synchroniser; only cond_reg reads the first stage.
  // The previous-value copy feeds the edge detector after the second stage.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sync1_reg <= '0;
      cond_reg <= '0;
      prev_reg <= '0;
    end
    else
    begin
      sync1_reg <= operation_group_summary_cond_in;
      cond_reg <= cond_next;
      prev_reg <= prev_next;
    end
  end

  // Condition holds the present state only.
  always_comb
  begin
    cond_next = sync1_reg;
    prev_next = cond_reg;
  end

  // Mask registers; clear-status does not touch them.
  always_comb
  begin
    cfg_next = cfg_reg;
    if (cfg_wr.ptr)
    begin
      cfg_next.ptr = cfg_in.ptr; // One enable per bit.
    end
    if (cfg_wr.ntr)
    begin
      cfg_next.ntr = cfg_in.ntr;
    end
    if (cfg_wr.ena)
    begin
      cfg_next.ena = cfg_in.ena;
    end
    if (cfg_wr.sre)
    begin
      cfg_next.sre = cfg_in.sre;
    end
  end

  // Filters gate rising and falling edges of the synchronised condition.
  // Comparing the second stage with its own delayed copy keeps the first
  // stage private, at the cost of one more cycle before the event sets.
  assign edges = edge_pass(cfg_reg.ptr, cond_reg, prev_reg)
               | edge_pass(cfg_reg.ntr, prev_reg, cond_reg);

  // Events are sticky; a new edge wins over a same-cycle clear.
  always_comb
  begin
    event_next = event_reg;
    if (clear_status)
    begin
      event_next = '0;
    end
    event_next = event_next | edges;
  end

  // Summary bits and service request.
  assign operation_group_summary_sum = |(event_reg & cfg_reg.ena);
  always_comb
  begin
    stb_raw = '0;
    stb_raw[ssr_pkg::OPERATION_GROUP_SUMMARY_SUM_BIT] = operation_group_summary_sum;
    srq_next = |(stb_raw & cfg_reg.sre);
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      event_reg <= '0;
      cfg_reg.ptr <= ssr_pkg::PTR_RESET; // Rising edges only.
      cfg_reg.ntr <= ssr_pkg::NTR_RESET;
      cfg_reg.ena <= ssr_pkg::ENA_RESET;
      cfg_reg.sre <= ssr_pkg::SRE_RESET;
      srq_reg <= 1'b0;
    end
    else
    begin
      event_reg <= event_next;
      cfg_reg <= cfg_next;
      srq_reg <= srq_next;
    end
  end

  // Status byte carries the master summary beside the group summary.
  always_comb
  begin
    status_byte = stb_raw;
    status_byte[ssr_pkg::MSS_BIT] = srq_reg;
  end

  assign operation_group_summary_cond = cond_reg;
  assign operation_group_summary_event = event_reg;
  assign cfg_out = cfg_reg;
  assign service_request = srq_reg;

  // Assertions.
  // Named steps of the service-request path on the gate-end bit.
  sequence s_gate_rise;
    cfg_reg.ptr[GATE_BIT] && cond_reg[GATE_BIT] && !prev_reg[GATE_BIT];
  endsequence
  sequence s_gate_armed;
    cfg_reg.ena[GATE_BIT] && cfg_reg.sre[SUM_BIT] && !(|cfg_wr);
  endsequence
  sequence s_request_up;
    status_byte[SUM_BIT] ##1 (service_request && status_byte[MSS_POS]);
  endsequence

  // A rising gate-end edge through the positive filter is latched.
  a_rise_latch: assert property (
    s_gate_rise |=> operation_group_summary_event[GATE_BIT])
    else $error("Rising edge on bit 9 not latched");

  // A falling gate-end edge through the negative filter is latched.
  a_fall_latch: assert property (
    (cfg_reg.ntr[GATE_BIT] && !cond_reg[GATE_BIT] && prev_reg[GATE_BIT])
    |=> operation_group_summary_event[GATE_BIT])
    else $error("Falling edge on bit 9 not latched");

  // With the negative filter at zero only rising edges move the events.
  a_fall_block: assert property (
    (cfg_reg.ntr == '0 && !clear_status
      && !(|edge_pass(cfg_reg.ptr, cond_reg, prev_reg)))
    |=> (operation_group_summary_event == $past(operation_group_summary_event)))
    else $error("Event changed without an enabled edge");

  // The gate-end event bit stays until clear-status.
  a_event_sticky: assert property (
    (operation_group_summary_event[GATE_BIT] && !clear_status) |=> operation_group_summary_event[GATE_BIT])
    else $error("Event bit lost without clear");

  // Clear-status with no edge pending empties the whole event register.
  a_clear_event: assert property (
    (clear_status && !(|edges)) |=> (operation_group_summary_event == '0))
    else $error("Clear-status left an event set");

  // Clear-status never touches the masks.
  a_clear_keep: assert property (
    (clear_status && !(|cfg_wr)) |=> (cfg_out == $past(cfg_out)))
    else $error("Clear-status changed an enable");

  // The group summary is the OR of the enabled events.
  a_sum_or: assert property (
    status_byte[SUM_BIT] == |(operation_group_summary_event & cfg_out.ena))
    else $error("Operation summary wrong");

  // An enabled summary raises the request on the next cycle.
  a_srq_follow: assert property (
    (status_byte[SUM_BIT] && cfg_out.sre[SUM_BIT]) |=> service_request)
    else $error("Service request not raised");

  // The request falls once no enabled summary remains.
  a_srq_drop: assert property (
    !(status_byte[SUM_BIT] && cfg_out.sre[SUM_BIT]) |=> !service_request)
    else $error("Service request not dropped");

  // The master summary bit mirrors the request.
  a_mss_bit: assert property (
    status_byte[MSS_POS] == service_request)
    else $error("Master summary mismatch");

  // A gate-end edge with both masks set walks through to the request.
  a_gate_srq: assert property (
    s_gate_rise ##0 s_gate_armed |=> s_request_up)
    else $error("Gate end did not reach the service request");

endmodule // ssr_status

`default_nettype wire

// ---- ssr_ctrl_model.sv ----
// Bus controller model that programs the status masks.
// Assumes the status block takes writes on the rising edge of ref_clk.
`timescale 1ns/1ns
`default_nettype none
module ssr_ctrl_model
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rstn,
  // Values to program and a one-cycle start pulse.
  input wire ssr_pkg::ssr_cfg_s val,
  input wire logic go,
  // Programming port of the status block.
  output ssr_pkg::ssr_cfg_s cfg_in,
  output ssr_pkg::ssr_wr_s cfg_wr
);
  logic [1:0] step_reg;
  logic [1:0] step_next;
  // Filters first, then event enable, then request enable.
  always_comb
    step_next = go ? 2'h1 : (step_reg == 2'h0 ? 2'h0 : step_reg + 2'h1);
  // Register the step.
  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
      step_reg <= 2'h0;
    else
      step_reg <= step_next;
  // Data passes straight through from val, so no write sees stale bits.
  assign cfg_in = val;
  assign cfg_wr = '{ptr: step_reg == 2'h1, ntr: step_reg == 2'h1,
    ena: step_reg == 2'h2, sre: step_reg == 2'h3};
endmodule // ssr_ctrl_model
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the status and service-request block.
// Assumes one 100 MHz clock; the controller model programs the masks.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  typedef struct packed {logic [15:0] c; logic [15:0] ev; logic [7:0] sb;}
    ssr_row_s;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic go = 1'b0;
  logic clear_status = 1'b0;
  logic [15:0] operation_group_summary_cond_in = 16'h0000;
  ssr_pkg::ssr_cfg_s val = '0;
  ssr_pkg::ssr_cfg_s cfg_in, cfg_out;
  ssr_pkg::ssr_wr_s cfg_wr;
  logic [15:0] operation_group_summary_cond, operation_group_summary_event;
  logic [7:0] status_byte;
  logic service_request;
  int num_errors = 0;
  int compares = 0;
  // Condition, expected events, expected status byte.
  ssr_row_s rows [4] = '{'{16'h0200, 16'h0200, 8'hc0},
    '{16'h0100, 16'h0000, 8'h00}, '{16'h0300, 16'h0200, 8'hc0},
    '{16'h0000, 16'h0000, 8'h00}};
  // Clock.
  always #5 ref_clk = ~ref_clk;
  ssr_status u_ssr_status (.ref_clk, .rstn, .operation_group_summary_cond_in, .cfg_in,
    .cfg_wr, .clear_status, .operation_group_summary_cond, .operation_group_summary_event, .cfg_out,
    .status_byte, .service_request);
  ssr_ctrl_model u_ssr_ctrl_model (.ref_clk, .rstn, .val, .go, .cfg_in,
    .cfg_wr);
  // Compare and count.
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Wait edges, then settle past the edge.
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic pulse_clr;
    @(posedge ref_clk) clear_status <= 1'b1;
    @(posedge ref_clk) clear_status <= 1'b0;
  endtask
  task automatic set_cond(input logic [15:0] c);
    @(posedge ref_clk) operation_group_summary_cond_in <= c;
    step(4);
  endtask
  task automatic wrap_up;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Watchdog, far beyond the hundred or so cycles the tests need.
  initial
  begin
    #20000;
    num_errors++;
    wrap_up;
  end
  // Main sequence.
  initial
  begin
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    step(1);
    chk(cfg_out, {16'hffff, 40'h0});
    set_cond(16'h0008);
    chk({operation_group_summary_event, status_byte}, {16'h0008, 8'h00});
    set_cond(16'h0000);
    chk(operation_group_summary_event, 16'h0008);
    pulse_clr;
    step(1);
    chk(operation_group_summary_event, 16'h0000);
    @(posedge ref_clk)
    begin
      val <= '{16'h0200, 16'h0000, 16'h0200, 8'h80};
      go <= 1'b1;
    end
    @(posedge ref_clk) go <= 1'b0;
    step(5);
    chk(cfg_out, {16'h0200, 16'h0000, 16'h0200, 8'h80});
    foreach (rows[i])
    begin
      set_cond(rows[i].c);
      chk({operation_group_summary_cond, operation_group_summary_event, status_byte, service_request},
        {rows[i].c, rows[i].ev, rows[i].sb, rows[i].sb[6]});
      pulse_clr;
    end
    set_cond(16'h0200);
    pulse_clr;
    step(2);
    chk({cfg_out, service_request}, {val, 1'b0});
    // Negative filter only: a falling gate-end edge raises the request.
    @(posedge ref_clk)
    begin
      val <= '{16'h0000, 16'h0200, 16'h0200, 8'h80};
      go <= 1'b1;
    end
    @(posedge ref_clk) go <= 1'b0;
    step(5);
    set_cond(16'h0000);
    chk({operation_group_summary_event, status_byte}, {16'h0200, 8'hc0});
    set_cond(16'h0200);
    chk(operation_group_summary_event, 16'h0200);
    // An edge latched in the same cycle as clear-status survives it.
    pulse_clr;
    @(posedge ref_clk) operation_group_summary_cond_in <= 16'h0000;
    @(posedge ref_clk);
    @(posedge ref_clk) clear_status <= 1'b1;
    @(posedge ref_clk) clear_status <= 1'b0;
    step(1);
    chk(operation_group_summary_event, 16'h0200);
    // A second reset brings back the power-on filters and drops the request.
    @(posedge ref_clk) rstn <= 1'b0;
    step(2);
    @(posedge ref_clk) rstn <= 1'b1;
    step(1);
    chk(cfg_out, {16'hffff, 40'h0});
    chk({operation_group_summary_event, status_byte}, 24'h0);
    wrap_up;
  end
endmodule // testbench
`default_nettype wire
